// >>> scbg_baud_gen.sv
`timescale 1ns/1ps

// Operation
// - Sixteen-bit reload value divides the bus clock
// - Counter rolls over once in each low and each high phase
// - Period is twice reload, two, plus delay
// - Upper sixteen reload bits read as zero
module scbg_baud_gen
	import scbg_pkg::*;
#(
	parameter int unsigned RELOAD_W = SCBG_RELOAD_W // Reload width
)(
	// Clock and reset
	input  logic        pclk,
	input  logic        presetn,
	// APB slave
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	// Serial clock pin, open drain
	input  logic        scl_i,
	output logic        scl_o,
	output logic        scl_oe
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	generate
		if (RELOAD_W < 3 || RELOAD_W > SCBG_RELOAD_W) begin : g_bad_width
			$error("Reload width must lie between 3 and 16");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [RELOAD_W-1:0]   reload; // Stored reload value
		logic                  en;     // Generator enable
		scbg_phase_type        phase;  // Current clock phase
		logic                  scl;    // Released level of the clock
		logic                  oe;     // Line driven low
		logic [SCBG_DLY_W-1:0] dly;    // Rise delay count
		logic [31:0]           rdata;  // Read data to bus
		logic                  rdy;    // Bus ready
		logic                  err;    // Bus error
		logic [RELOAD_W-1:0]   hcnt;   // Cycles spent high, checking only
		logic [RELOAD_W-1:0]   href;   // Reload seen on entering high
	} scbg_state_type;

	scbg_state_type st_q;
	scbg_state_type st_d;

	// Counter control and status
	logic load;      // Reload counter from stored value
	logic run;       // Counter running in a phase
	logic rollover;  // Counter hit zero this cycle
	logic line_lvl;  // Synchronised clock line level

	// Bus decode
	logic setup;     // First cycle of a transfer
	logic wr_done;   // Write completes this edge

	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------

	// Line readback through two flops
	scbg_sync2 u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (scl_i),
		.sync_out (line_lvl)
	);

	// Phase length counter
	scbg_reload_counter #(
		.WIDTH (RELOAD_W)
	) u_cnt (
		.pclk       (pclk),
		.presetn    (presetn),
		.load       (load),
		.run        (run),
		.load_value (st_q.reload),
		.rollover   (rollover)
	);

	// Counter idles loaded, runs only in the timed phases
	assign load = (st_q.phase == SCBG_IDLE) || (st_q.phase == SCBG_RISE);
	assign run  = st_q.en && ((st_q.phase == SCBG_LOW) || (st_q.phase == SCBG_HIGH));

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign setup   = psel && !penable && !st_q.rdy;
	assign wr_done = psel && penable && st_q.rdy && pwrite;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// Bus answers, register writes and phase sequencing
	always_comb begin
		st_d       = st_q;
		st_d.rdy   = 1'b0;
		st_d.err   = 1'b0;
		st_d.rdata = '0;

		// Setup cycle: prepare answer for the access phase
		if (setup) begin
			st_d.rdy = 1'b1;
			case (paddr)
				SCBG_ADDR_RELOAD: begin
					// Unimplemented upper bits read as zero
					st_d.rdata[RELOAD_W-1:0] = st_q.reload;
				end
				SCBG_ADDR_CTRL: begin
					st_d.rdata[SCBG_CTRL_EN_BIT] = st_q.en;
				end
				SCBG_ADDR_STATUS: begin
					st_d.rdata[SCBG_STAT_SCL_BIT]  = st_q.scl;
					st_d.rdata[SCBG_STAT_RUN_BIT]  = (st_q.phase != SCBG_IDLE);
					st_d.rdata[SCBG_STAT_LINE_BIT] = line_lvl;
				end
				default: begin
					// Unmapped address answers with an error
					st_d.err = 1'b1;
				end
			endcase
		end

		// Access phase end: writes take effect
		if (wr_done) begin
			case (paddr)
				SCBG_ADDR_RELOAD: begin
					// Taken at once, used at the next reload
					st_d.reload = pwdata[RELOAD_W-1:0];
				end
				SCBG_ADDR_CTRL: begin
					st_d.en = pwdata[SCBG_CTRL_EN_BIT];
				end
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end

		// High time bookkeeping for checking
		st_d.hcnt = (st_q.phase == SCBG_HIGH) ? st_q.hcnt + 1'b1 : '0;

		// Clock phase sequencing
		case (st_q.phase)
			SCBG_IDLE: begin
				// Released line, start low phase on enable
				st_d.scl = 1'b1;
				if (st_q.en) begin
					st_d.phase = SCBG_LOW;
					st_d.scl   = 1'b0;
				end
			end
			SCBG_LOW: begin
				// First rollover ends the low phase
				if (rollover) begin
					st_d.phase = SCBG_RISE;
					st_d.scl   = 1'b1;
					st_d.dly   = '0;
				end
			end
			SCBG_RISE: begin
				// Fixed delay term added once per period
				st_d.href = st_q.reload;
				if (st_q.dly == SCBG_DLY_W'(SCBG_DELAY_CYC - 1)) begin
					st_d.phase = SCBG_HIGH;
				end else begin
					st_d.dly = st_q.dly + 1'b1;
				end
			end
			SCBG_HIGH: begin
				// Second rollover ends the period
				if (rollover) begin
					st_d.phase = SCBG_LOW;
					st_d.scl   = 1'b0;
				end
			end
			default: begin
				st_d.phase = SCBG_IDLE;
				st_d.scl   = 1'b1;
			end
		endcase

		// Disabled: no phase advance, line released
		if (!st_q.en) begin
			st_d.phase = SCBG_IDLE;
			st_d.scl   = 1'b1;
		end

		// Drive enable registered with the level, so the pin comes from a flop
		st_d.oe = !st_d.scl;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Single register for all block state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{reload: RELOAD_W'(SCBG_RELOAD_RST),
			          en:     SCBG_CTRL_EN_RST,
			          phase:  SCBG_IDLE,
			          scl:    1'b1,
			          oe:     1'b0,
			          dly:    '0,
			          rdata:  '0,
			          rdy:    1'b0,
			          err:    1'b0,
			          hcnt:   '0,
			          href:   '0};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata  = st_q.rdata;
	assign pready  = st_q.rdy;
	assign pslverr = st_q.err;
	assign scl_o   = st_q.scl;
	assign scl_oe  = st_q.oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	// Reload write lands in the stored value
	property p_reload_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_done && paddr == SCBG_ADDR_RELOAD)
		|=> (st_q.reload == $past(pwdata[RELOAD_W-1:0]));
	endproperty
	a_reload_write: assert property (p_reload_write)
		else $error("Reload value not stored on write");

	// Reload read shows value with zero upper bits
	property p_reload_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && !pwrite && paddr == SCBG_ADDR_RELOAD)
		|-> (prdata == 32'(st_q.reload));
	endproperty
	a_reload_read: assert property (p_reload_read)
		else $error("Reload readback wrong or upper bits set");

	// High phase lasts reload plus one cycles
	property p_high_len;
		@(posedge pclk) disable iff (!presetn)
		(st_q.phase == SCBG_HIGH && rollover)
		|-> (st_q.hcnt == st_q.href) ##1 (st_q.phase == SCBG_LOW && !scl_o);
	endproperty
	a_high_len: assert property (p_high_len)
		else $error("High phase length or next phase wrong");

	// Low rollover is followed by the fixed delay, then high
	sequence s_rise;
		(st_q.phase == SCBG_RISE && scl_oe == 1'b0) [*2] ##1 (st_q.phase == SCBG_HIGH);
	endsequence

	property p_rise_delay;
		@(posedge pclk) disable iff (!presetn || !st_q.en)
		(st_q.phase == SCBG_LOW && rollover) |=> s_rise;
	endproperty
	a_rise_delay: assert property (p_rise_delay)
		else $error("Delay term between phases wrong");

	// Low phase drives the line until its rollover
	property p_low_drive;
		@(posedge pclk) disable iff (!presetn)
		(st_q.phase == SCBG_LOW) |-> (scl_oe && !scl_o);
	endproperty
	a_low_drive: assert property (p_low_drive)
		else $error("Line not driven low in low phase");

	// Disable stops the generator at once
	property p_disable;
		@(posedge pclk) disable iff (!presetn)
		!st_q.en |=> (st_q.phase == SCBG_IDLE && scl_o && !scl_oe);
	endproperty
	a_disable: assert property (p_disable)
		else $error("Generator ran while disabled");

	// Counter never advances while disabled
	property p_no_run;
		@(posedge pclk) disable iff (!presetn)
		!st_q.en |-> !rollover;
	endproperty
	a_no_run: assert property (p_no_run)
		else $error("Rollover while disabled");

endmodule

// >>> scbg_pkg.sv
package scbg_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] SCBG_ADDR_RELOAD = 8'h00; // Reload value
	localparam logic [7:0] SCBG_ADDR_CTRL   = 8'h04; // Control
	localparam logic [7:0] SCBG_ADDR_STATUS = 8'h08; // Status

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned SCBG_RELOAD_W        = 16;       // Implemented reload bits
	localparam logic [15:0] SCBG_RELOAD_RST      = 16'h0000; // Reload after reset
	localparam int unsigned SCBG_CTRL_EN_BIT     = 0;        // Generator enable
	localparam logic        SCBG_CTRL_EN_RST     = 1'b0;     // Disabled after reset
	localparam int unsigned SCBG_STAT_SCL_BIT    = 0;        // Generated clock level
	localparam int unsigned SCBG_STAT_RUN_BIT    = 1;        // Generator running
	localparam int unsigned SCBG_STAT_LINE_BIT   = 2;        // Sampled line level

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned SCBG_CLK_KHZ   = 10000; // Peripheral bus clock rate
	localparam int unsigned SCBG_DELAY_NS  = 130;   // Fixed line delay term
	// Least time, so round the cycle count up
	localparam int unsigned SCBG_DELAY_CYC = (SCBG_DELAY_NS * SCBG_CLK_KHZ + 999999) / 1000000;
	localparam int unsigned SCBG_DLY_W     = 4;     // Width of delay counter

	// ----------------------------------------------------------------
	// Clock phases, Gray coded along idle -> low -> rise -> high
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCBG_IDLE = 2'b00,
		SCBG_LOW  = 2'b01,
		SCBG_RISE = 2'b11,
		SCBG_HIGH = 2'b10
	} scbg_phase_type;

endpackage

// >>> scbg_reload_counter.sv
`timescale 1ns/1ps

module scbg_reload_counter
	import scbg_pkg::*;
#(
	parameter int unsigned WIDTH = SCBG_RELOAD_W // Counter width
)(
	// Clock and reset
	input  logic             pclk,
	input  logic             presetn,
	// Control
	input  logic             load,       // Force a reload
	input  logic             run,        // Count down when high
	input  logic [WIDTH-1:0] load_value, // Value taken on reload
	// Status
	output logic             rollover    // Count reached zero while running
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] cnt; // Down counter
	} scbg_cnt_type;

	scbg_cnt_type st_q;
	scbg_cnt_type st_d;

	// Zero while running ends this phase
	assign rollover = run && (st_q.cnt == '0);

	// Reload on request or rollover, else count down while running, else hold
	always_comb begin
		st_d = st_q;
		if (load || rollover) begin
			st_d.cnt = load_value;
		end else if (run) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
	end

	// Register the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{cnt: '0};
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// >>> scbg_scl_client.sv
`timescale 1ns/1ps

// ------------------------------------------------
// Serial clock line with pull-up and client hold
// ------------------------------------------------
module scbg_scl_client (
	// Generator drive
	input  wire logic scl_oe,
	// Client may hold the line low
	input  wire logic hold_low,
	// Resolved line
	output wire logic scl_line
);
	// Any party low wins, else the pull-up
	assign scl_line = (scl_oe === 1'b1 || hold_low === 1'b1) ? 1'b0 : 1'b1;
endmodule

// >>> scbg_sync2.sv
`timescale 1ns/1ps

module scbg_sync2
	import scbg_pkg::*;
(
	// Clock and reset
	input  logic pclk,
	input  logic presetn,
	// Asynchronous level in, synchronised level out
	input  logic async_in,
	output logic sync_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic first;  // First stage, read only by second
		logic second; // Second stage, safe to use
	} scbg_sync_type;

	scbg_sync_type st_q;
	scbg_sync_type st_d;

	// Shift the level through both stages
	always_comb begin
		st_d        = st_q;
		st_d.first  = async_in;
		st_d.second = st_q.first;
	end

	// Register the stages, line idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{first: 1'b1, second: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.second;

endmodule

// >>> tb_scbg_baud_gen.sv
`timescale 1ns/1ps

module tb_scbg_baud_gen
	import scbg_pkg::*;
;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic        pclk     = 1'b0;  // Bus clock
	logic        presetn  = 1'b0;  // Reset, active low
	logic        psel     = 1'b0;  // APB select
	logic        penable  = 1'b0;  // APB access
	logic        pwrite   = 1'b0;  // APB direction
	logic [7:0]  paddr    = 8'h00; // APB address
	logic [31:0] pwdata   = 32'h0; // APB write data
	logic [31:0] prdata;           // APB read data
	logic        pready;           // APB ready
	logic        pslverr;          // APB error
	logic        hold_low = 1'b0;  // Client hold
	wire         scl_line;         // Resolved line
	logic        scl_o;            // Generated level
	logic        scl_oe;           // Generator drives low
	int          bad_count   = 0;  // Mismatches
	int          comparisons = 0;  // Checks made
	logic [31:0] seed = 32'h4a43;  // Random state
	int unsigned m_reload = 0;     // Model reload

	// Clock, 100 ns period
	always #50 pclk = ~pclk;

	scbg_baud_gen i_scbg_baud_gen (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_i(scl_line), .scl_o(scl_o),
		.scl_oe(scl_oe)
	);
	scbg_scl_client i_scbg_scl_client (
		.scl_oe(scl_oe), .hold_low(hold_low), .scl_line(scl_line)
	);

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	// Xorshift random source
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer, entered right after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Write, update the model, check the error flag
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
		chk("wr_err", {31'h0, a > SCBG_ADDR_STATUS}, {31'h0, er});
		if (a == SCBG_ADDR_RELOAD) m_reload = d & 32'hffff;
	endtask

	// Read and compare with the model value
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(nm, e, rd);
		chk("rd_err", {31'h0, a > SCBG_ADDR_STATUS}, {31'h0, er});
	endtask

	// Measure two periods, then switch off and watch it stay idle
	task automatic run_period(input int r);
		int lo, hi, n;
		wr(SCBG_ADDR_RELOAD, r);
		wr(SCBG_ADDR_CTRL, 32'h1);
		n = 0;
		while (scl_o !== 1'b0 && n < 20) begin
			@(negedge pclk);
			n++;
		end
		repeat (2) begin
			chk("scl_oe_low", 32'h1, {31'h0, scl_oe});
			lo = 0;
			while (scl_o === 1'b0 && lo < 99999) begin
				@(negedge pclk);
				lo++;
			end
			hi = 0;
			while (scl_o === 1'b1 && hi < 99999) begin
				@(negedge pclk);
				hi++;
			end
			chk("low_cycles", m_reload + 1, lo);
			chk("high_cycles", m_reload + 1 + SCBG_DELAY_CYC, hi);
		end
		// Two cycles into the low phase: driven low, running, line seen low
		repeat (2) @(posedge pclk);
		rdc(SCBG_ADDR_STATUS, 32'h2, "status_run");
		wr(SCBG_ADDR_CTRL, 32'h0);
		n = 0;
		repeat (2 * r + 8) begin
			@(negedge pclk);
			n += (scl_o !== 1'b1 || scl_oe !== 1'b0);
		end
		chk("idle_after_off", 32'h0, n);
		@(posedge pclk);
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		logic [31:0] v;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("scl_o_rst", 32'h1, {31'h0, scl_o});
		chk("scl_oe_rst", 32'h0, {31'h0, scl_oe});
		rdc(SCBG_ADDR_RELOAD, 32'h0, "reload_rst");
		rdc(SCBG_ADDR_CTRL, 32'h0, "ctrl_rst");
		// Random words, upper half must read back zero
		repeat (4) begin
			v = xs();
			wr(SCBG_ADDR_RELOAD, v);
			rdc(SCBG_ADDR_RELOAD, m_reload, "reload_rd");
		end
		// Unmapped places answer with an error
		wr(8'h0c, xs());
		rdc(8'h10, 32'h0, "unmapped_rd");
		// Line level read back while a client holds it
		hold_low <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc(SCBG_ADDR_STATUS, 32'h1, "status_held");
		hold_low <= 1'b0;
		repeat (4) @(posedge pclk);
		wr(SCBG_ADDR_STATUS, 32'hffffffff);
		rdc(SCBG_ADDR_STATUS, 32'h5, "status_free");
		// Periods at the smallest legal reload, the next one, and one random reload
		run_period(4);
		run_period(5);
		run_period(4 + xs() % 13);
		summarize();
	end

	// Watchdog
	initial begin
		#5000000;
		bad_count++;
		$display("[ERR] watchdog expired");
		summarize();
	end
endmodule
